/* rtl/sbsr_defs.vh */
// Constants for the status byte and service request block
`ifndef SBSR_DEFS_VH
`define SBSR_DEFS_VH
`define SBSR_BIT_MEAS      0
`define SBSR_BIT_UNUSED    1
`define SBSR_BIT_ERRQ      2
`define SBSR_BIT_QUES      3
`define SBSR_BIT_RESP      4
`define SBSR_BIT_STD       5
`define SBSR_BIT_RQS       6
`define SBSR_BIT_OPER      7
`define SBSR_SUM_MASK      8'hbd
`define SBSR_MASK_RESET    8'h00
`define SBSR_SEL_STB       2'h0
`define SBSR_SEL_MASK      2'h1
`define SBSR_SEL_POLL      2'h2
`endif

/* rtl/sbsr_summary.v */
// Status byte summary bits and master summary combiner
`timescale 1ns/1ps
`include "sbsr_defs.vh"
module sbsr_summary (
    // Summary inputs
    input  wire       meas_summary_i,
    input  wire       error_queue_nonempty_i,
    input  wire       questionable_summary_i,
    input  wire       response_pending_i,
    input  wire       standard_event_summary_i,
    input  wire       operation_summary_i,
    // Enable mask
    input  wire [7:0] mask_i,
    // Results
    output wire [7:0] summary_o,
    output wire       master_o
);
    // Bit 1 and bit 6 are zero here; bit 6 is added by the caller
    assign summary_o = {operation_summary_i,
                        1'b0,
                        standard_event_summary_i,
                        response_pending_i,
                        questionable_summary_i,
                        error_queue_nonempty_i,
                        1'b0,
                        meas_summary_i};
    assign master_o = |(summary_o & mask_i & `SBSR_SUM_MASK);
endmodule // sbsr_summary

/* rtl/sbsr_read_mux.v */
// Read value selection and binary-weight formatting
`timescale 1ns/1ps
`include "sbsr_defs.vh"
module sbsr_read_mux (
    // Sources
    input  wire [7:0] summary_i,
    input  wire       master_i,
    input  wire       rqs_i,
    input  wire [7:0] mask_i,
    // Select
    input  wire [1:0] sel_i,
    // Result
    output reg  [15:0] value_o
);
    always @* begin
        case (sel_i)
            `SBSR_SEL_STB:  value_o = {8'h00, summary_i | {1'b0, master_i, 6'h00}};
            `SBSR_SEL_MASK: value_o = {8'h00, mask_i};
            `SBSR_SEL_POLL: value_o = {8'h00, summary_i | {1'b0, rqs_i, 6'h00}};
            default:        value_o = 16'h0000;
        endcase
    end
endmodule // sbsr_read_mux

/* rtl/sbsr_top.v */
// Status byte, service request mask and request-service logic
`timescale 1ns/1ps
`include "sbsr_defs.vh"
// Notes on behaviour
// - Only the enable mask is writable; status byte is read-only.
// - Write value is a decimal integer; bit n has weight two to n.
// - Queries return register contents as one binary-weighted integer.
// - Requests use two eight-bit registers: status byte and enable mask.
// - Summary bits 0,2,3,4,5,7 follow inputs without latching.
// - Bit 0 is measurement summary; bit 1 always reads zero.
// - Bit 2 set while error queue holds an entry.
// - Bit 3 set while enabled questionable event present.
// - Bit 4 set while an unread response waits in output queue.
// - Bit 5 is standard event summary; bit 7 operation summary.
// - Summary bits ANDed with mask then ORed into bit 6.
// - Rising enabled summary sets request flag and asserts bus request.
// - Finished poll clears flag; pending event may request again.
// - Serial poll leaves master summary alone until all enabled bits clear.
// - Controller polls with enable/disable commands; device returns poll byte.
// - Mask writable 0 to 255 and readable back.
// - Mask clears at power-up and when zero is written.
// - Clear-status and preset commands leave the mask unchanged.
// - At power-up all status bits are zero and queues empty.
module sbsr_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Summary inputs
    input  wire        meas_summary_i,
    input  wire        error_queue_nonempty_i,
    input  wire        questionable_summary_i,
    input  wire        response_pending_i,
    input  wire        standard_event_summary_i,
    input  wire        operation_summary_i,
    // Command port
    input  wire        mask_write_i,
    input  wire [15:0] mask_data_i,
    input  wire        stb_query_i,
    input  wire        mask_query_i,
    input  wire        clear_status_i,
    input  wire        preset_i,
    // Serial poll
    input  wire        poll_enable_i,
    input  wire        poll_disable_i,
    // Query answer
    output reg  [15:0] query_value_o,
    output reg         query_valid_o,
    // Serial poll answer
    output reg  [7:0]  poll_byte_o,
    output reg         poll_active_o,
    // Request and live status
    output reg         service_request_o,
    output reg  [7:0]  summary_status_byte_o,
    output reg         master_summary_value_o
);
    // Serial poll sequence states
    localparam [1:0] POLL_IDLE = 2'b00;
    localparam [1:0] POLL_OPEN = 2'b01;

    // Stored state
    reg  [7:0]  service_request_mask;
    reg         request_service_flag;
    reg  [7:0]  enabled_prev;
    reg  [1:0]  poll_state;

    // Combinational results
    reg  [1:0]  next_poll_state;
    reg         next_flag;
    reg  [7:0]  next_mask;
    reg  [7:0]  next_poll_byte;
    reg  [1:0]  sel;
    wire [7:0]  summary;
    wire        master;
    wire [15:0] value;
    wire [7:0]  enabled_now;
    wire        enabled_rise;
    wire        polling;
    wire        poll_close;
    wire        any_query;

    // Summary bits that may request service; mask bit 6 never counts
    function [7:0] sbsr_enabled;
        input [7:0] bits;
        input [7:0] mask;
        begin
            sbsr_enabled = bits & mask & `SBSR_SUM_MASK;
        end
    endfunction

    // True when any bit went from zero to one since the last edge
    function sbsr_any_rise;
        input [7:0] now;
        input [7:0] prev;
        begin
            sbsr_any_rise = |(now & ~prev);
        end
    endfunction

    // Status byte with bit 6 taken from the given source
    function [7:0] sbsr_with_b6;
        input [7:0] bits;
        input       b6;
        begin
            sbsr_with_b6 = {bits[7], b6, bits[5:0]};
        end
    endfunction

    // Low byte of the written value; higher weights have no bit to land in
    function [7:0] sbsr_mask_value;
        input [15:0] data;
        begin
            sbsr_mask_value = data[7:0];
        end
    endfunction

    // Request detection and poll bookkeeping
    assign enabled_now  = sbsr_enabled(summary, service_request_mask);
    assign enabled_rise = sbsr_any_rise(enabled_now, enabled_prev);
    assign polling      = (poll_state == POLL_OPEN);
    assign poll_close   = polling & poll_disable_i;
    assign any_query    = stb_query_i | mask_query_i;

    sbsr_summary u_summary (
        .meas_summary_i           (meas_summary_i),
        .error_queue_nonempty_i   (error_queue_nonempty_i),
        .questionable_summary_i   (questionable_summary_i),
        .response_pending_i       (response_pending_i),
        .standard_event_summary_i (standard_event_summary_i),
        .operation_summary_i      (operation_summary_i),
        .mask_i                   (service_request_mask),
        .summary_o                (summary),
        .master_o                 (master)
    );

    sbsr_read_mux u_mux (
        .summary_i (summary),
        .master_i  (master),
        .rqs_i     (request_service_flag),
        .mask_i    (service_request_mask),
        .sel_i     (sel),
        .value_o   (value)
    );

    // Mask query first, then status byte query, then poll, so a status byte query sees the live summary
    always @* begin
        if (mask_query_i) begin
            sel = `SBSR_SEL_MASK;
        end else if (stb_query_i) begin
            sel = `SBSR_SEL_STB;
        end else if (poll_enable_i) begin
            sel = `SBSR_SEL_POLL;
        end else begin
            sel = `SBSR_SEL_STB;
        end
    end

    // Next poll state: enable opens, disable closes
    always @* begin
        case (poll_state)
            POLL_IDLE: begin
                if (poll_enable_i) begin
                    next_poll_state = POLL_OPEN;
                end else begin
                    next_poll_state = POLL_IDLE;
                end
            end
            POLL_OPEN: begin
                if (poll_enable_i) begin
                    next_poll_state = POLL_OPEN;
                end else if (poll_disable_i) begin
                    next_poll_state = POLL_IDLE;
                end else begin
                    next_poll_state = POLL_OPEN;
                end
            end
            default: begin
                next_poll_state = POLL_IDLE;
            end
        endcase
    end

    // Poll state register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            poll_state <= POLL_IDLE;
        end else begin
            poll_state <= next_poll_state;
        end
    end

    // Set wins over the poll clear, so a fresh event is never lost
    always @* begin
        if (enabled_rise) begin
            next_flag = 1'b1;
        end else if (poll_close) begin
            next_flag = 1'b0;
        end else begin
            next_flag = request_service_flag;
        end
    end

    // Request flag and the enabled bits seen at the last edge
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            request_service_flag <= 1'b0;
            enabled_prev         <= 8'h00;
        end else begin
            request_service_flag <= next_flag;
            enabled_prev         <= enabled_now;
        end
    end

    // Next mask: only a write changes it; clear-status and preset have no path
    always @* begin
        if (mask_write_i) begin
            next_mask = sbsr_mask_value(mask_data_i);
        end else begin
            next_mask = service_request_mask;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            service_request_mask <= `SBSR_MASK_RESET;
        end else begin
            service_request_mask <= next_mask;
        end
    end

    // Query answer
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            query_valid_o <= 1'b0;
        end else begin
            query_valid_o <= any_query;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            query_value_o <= 16'h0000;
        end else if (any_query) begin
            query_value_o <= value;
        end
    end

    // Poll byte; a coinciding query owns the mux, so build it directly then
    always @* begin
        if (any_query) begin
            next_poll_byte = sbsr_with_b6(summary, request_service_flag);
        end else begin
            next_poll_byte = value[7:0];
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            poll_byte_o <= 8'h00;
        end else if (poll_enable_i) begin
            poll_byte_o <= next_poll_byte;
        end
    end

    // Poll stays active from enable to disable
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            poll_active_o <= 1'b0;
        end else begin
            poll_active_o <= (next_poll_state == POLL_OPEN);
        end
    end

    // Request line follows the flag's next value, so both move together
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            service_request_o <= 1'b0;
        end else begin
            service_request_o <= next_flag;
        end
    end

    // Live status byte; bit 6 is the master summary
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            summary_status_byte_o <= 8'h00;
        end else begin
            summary_status_byte_o <= sbsr_with_b6(summary, master);
        end
    end

    // Serial polls do not reach the master summary
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            master_summary_value_o <= 1'b0;
        end else begin
            master_summary_value_o <= master;
        end
    end
endmodule // sbsr_top

/* test/sbsr_ctrl_model.sv */
// Bus controller model that serial polls on a service request
`timescale 1ns/1ps
module sbsr_ctrl_model #(parameter int WAIT_CYC = 2) (
    input  wire  clk_i,
    input  wire  rst_i,
    input  wire  srq_i,
    output logic spe_o,
    output logic spd_o,
    output logic done_o
);
    initial begin
        spe_o = 1'b0;
        spd_o = 1'b0;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (srq_i && !rst_i) begin
                repeat (WAIT_CYC) @(posedge clk_i);
                spe_o <= 1'b1;
                @(posedge clk_i) spe_o <= 1'b0;
                @(posedge clk_i) spd_o <= 1'b1;
                @(posedge clk_i) spd_o <= 1'b0;
                done_o <= 1'b1;
                @(posedge clk_i) done_o <= 1'b0;
            end
        end
    end
endmodule // sbsr_ctrl_model

/* test/sbsr_assertions.sv */
// Assertions on the status byte block ports
`timescale 1ns/1ps
module sbsr_checker (
    input wire clk_i, rst_i, mask_write_i, stb_query_i, mask_query_i, poll_enable_i,
    input wire meas_summary_i, error_queue_nonempty_i, questionable_summary_i,
    input wire response_pending_i, standard_event_summary_i, operation_summary_i,
    input wire poll_disable_i, query_valid_o, poll_active_o, service_request_o,
    input wire master_summary_value_o,
    input wire [15:0] mask_data_i, query_value_o,
    input wire [7:0] summary_status_byte_o
);
    reg  [7:0] mask_m;
    reg  [7:0] en_prev;
    wire [7:0] src = {operation_summary_i, 1'b0, standard_event_summary_i, response_pending_i,
        questionable_summary_i, error_queue_nonempty_i, 1'b0, meas_summary_i};
    wire [7:0] en  = src & mask_m & 8'hbd;
    always @(posedge clk_i or posedge rst_i)
        if (rst_i) mask_m <= 8'h00;
        else if (mask_write_i) mask_m <= mask_data_i[7:0];
    always @(posedge clk_i or posedge rst_i)
        if (rst_i) en_prev <= 8'h00;
        else en_prev <= en;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bits_follow: assert property ((summary_status_byte_o & 8'hbf) == $past(src))
        else $error("summary bits wrong");
    a_bit6_master: assert property (summary_status_byte_o[6] == master_summary_value_o)
        else $error("bit 6 wrong");
    a_master_or: assert property ($stable(mask_m) |-> master_summary_value_o ==
        |(summary_status_byte_o & mask_m & 8'hbd)) else $error("master wrong");
    a_mask_read: assert property (mask_query_i && !mask_write_i |=> query_valid_o &&
        query_value_o == {8'h00, mask_m}) else $error("mask readback wrong");
    a_valid_cause: assert property (query_valid_o |-> $past(stb_query_i || mask_query_i))
        else $error("stray valid");
    a_srq_rise: assert property ($rose(master_summary_value_o) |-> ##[0:2] service_request_o)
        else $error("no request");
    a_bit_rise: assert property (|(en & ~en_prev) |=> service_request_o)
        else $error("rising bit gave no request");
    a_srq_clear: assert property (poll_disable_i && poll_active_o && !(|(en & ~en_prev))
        |=> !service_request_o) else $error("request kept");
    a_poll_active: assert property (poll_enable_i |=> poll_active_o)
        else $error("poll inactive");
endmodule // sbsr_checker
bind sbsr_top sbsr_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .mask_write_i(mask_write_i),
    .stb_query_i(stb_query_i), .mask_query_i(mask_query_i), .poll_enable_i(poll_enable_i),
    .meas_summary_i(meas_summary_i), .error_queue_nonempty_i(error_queue_nonempty_i),
    .questionable_summary_i(questionable_summary_i), .response_pending_i(response_pending_i),
    .standard_event_summary_i(standard_event_summary_i), .operation_summary_i(operation_summary_i),
    .poll_disable_i(poll_disable_i), .query_valid_o(query_valid_o), .poll_active_o(poll_active_o),
    .service_request_o(service_request_o), .master_summary_value_o(master_summary_value_o),
    .mask_data_i(mask_data_i), .query_value_o(query_value_o),
    .summary_status_byte_o(summary_status_byte_o));

/* test/sbsr_top_tb.sv */
// Testbench for the status byte block
`timescale 1ns/1ps
module sbsr_top_tb;
    logic clk_i = 0, rst_i = 1, mask_write_i = 0, stb_query_i = 0, mask_query_i = 0;
    logic clear_status_i = 0, preset_i = 0, spe, spd, done, qv, pa, srq, ms;
    logic [5:0] src = 0;
    logic [15:0] mask_data_i = 0, qval;
    logic [7:0] pbyte, sbyte, mask_ref = 0;
    int mismatches = 0, total_checks = 0;
    always #25 clk_i = ~clk_i;
    sbsr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .meas_summary_i(src[0]),
        .error_queue_nonempty_i(src[1]), .questionable_summary_i(src[2]),
        .response_pending_i(src[3]), .standard_event_summary_i(src[4]),
        .operation_summary_i(src[5]), .mask_write_i(mask_write_i), .mask_data_i(mask_data_i),
        .stb_query_i(stb_query_i), .mask_query_i(mask_query_i), .clear_status_i(clear_status_i),
        .preset_i(preset_i), .poll_enable_i(spe), .poll_disable_i(spd), .query_value_o(qval),
        .query_valid_o(qv), .poll_byte_o(pbyte), .poll_active_o(pa), .service_request_o(srq),
        .summary_status_byte_o(sbyte), .master_summary_value_o(ms));
    sbsr_ctrl_model #(.WAIT_CYC(3)) i_ctrl (.clk_i(clk_i), .rst_i(rst_i), .srq_i(srq),
        .spe_o(spe), .spd_o(spd), .done_o(done));
    function automatic logic [15:0] stb_ref();
        logic [7:0] b;
        b = {src[5], 1'b0, src[4:1], 1'b0, src[0]};
        return {8'h00, b | {1'b0, |(b & mask_ref & 8'hbd), 6'h00}};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic query(input int k, input logic [15:0] e);
        @(posedge clk_i);
        case (k) 0: stb_query_i <= 1; 1: mask_query_i <= 1; 2: clear_status_i <= 1;
            default: preset_i <= 1; endcase
        @(posedge clk_i) {stb_query_i, mask_query_i, clear_status_i, preset_i} <= 4'h0;
        #1 if (k < 2) chk("query", e, qv ? qval : 16'hffff);
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge clk_i) mask_write_i <= 1;
        mask_data_i <= {8'($urandom), v};
        mask_ref = v;
        @(posedge clk_i) mask_write_i <= 0;
    endtask
    task automatic raise();
        @(posedge clk_i) src <= 6'h02;
        repeat (3) @(posedge clk_i);
        #1 chk("request", 1, srq);
    endtask
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(88995));
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        query(0, 0);
        query(1, 0);
        repeat (12) begin
            wr(8'($urandom_range(0, 255)));
            @(posedge clk_i) src <= 6'($urandom_range(0, 63));
            repeat (3) @(posedge clk_i);
            query(0, stb_ref());
            query(1, {8'h00, mask_ref});
        end
        @(posedge clk_i) src <= 0;
        repeat (15) @(posedge clk_i);
        wr(8'h04);
        raise();
        for (int i = 0; i < 20 && !done; i++) @(posedge clk_i) #1;
        chk("poll byte", 16'h44, pbyte);
        #100 chk("request", 0, srq);
        chk("master", 1, ms);
        query(0, 16'd68);
        @(posedge clk_i) src <= 0;
        raise();
        query(2, 0);
        query(3, 0);
        query(1, 16'h04);
        wr(8'h00);
        query(1, 0);
        conclude();
    end
    initial begin
        #(50 * 3000);
        mismatches++;
        conclude();
    end
endmodule // sbsr_top_tb
